//--- logic/fold_pkg.sv
// Shared constants, register map and carrier types of the folded flow front end
package fold_pkg;

	// ------------------------------------------------------------
	// Widths and sizes
	// ------------------------------------------------------------
	localparam int DATA_W     = 16;
	localparam int CH_W       = 2;
	localparam int NUM_CH     = 4;
	localparam int FIFO_DEPTH = 32;
	localparam int ADDR_W     = 8;
	localparam int CYC_W      = 8;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_TIMING = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
	localparam logic [3:0]        CHAN_PAGE  = 4'h1;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_PSO_BIT  = 0;
	localparam int CTRL_HOLD_BIT = 1;
	localparam int CTRL_CHN_LSB  = 2;
	localparam int TIM_OP_LSB    = 0;
	localparam int TIM_MAX_LSB   = 8;
	localparam int STAT_IDLE_BIT = 0;
	localparam int STAT_EMPTY    = 1;
	localparam int STAT_FULL     = 2;
	localparam int STAT_LATE     = 3;
	localparam int STAT_DROP     = 4;
	localparam int STAT_LVL_LSB  = 8;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic             RST_PSO       = 1'b1;
	localparam logic             RST_HOLD      = 1'b0;
	localparam logic [CH_W-1:0]  RST_CHN       = 2'h0;
	localparam logic [CYC_W-1:0] RST_OP_CYCLES = 8'h04;
	localparam logic [CYC_W-1:0] RST_MAX_LAT   = 8'h10;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01
	} proc_e;

	typedef struct packed {
		logic [CH_W-1:0]   ch;
		logic [DATA_W-1:0] data;
	} sample_s;

endpackage

//--- logic/fifo_buf.sv
// Result FIFO with registered read data and honest full and empty
`timescale 1ns/1ps
`default_nettype none
module fifo_buf #(
	parameter int W     = 18,
	parameter int DEPTH = 32
) (
	input  wire logic                     mclk,      // Core clock
	input  wire logic                     rst_n,     // Sync reset, low
	input  wire logic                     in_valid,  // Write request
	output logic                          in_ready,  // Room for a word
	input  wire logic [W-1:0]             in_data,   // Write data
	output logic                          out_valid, // Read word present
	input  wire logic                     out_ready, // Reader takes word
	output logic [W-1:0]                  out_data,  // Registered word
	output logic [$clog2(DEPTH)+1:0]      level      // Words held
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    ov;
		logic [W-1:0]            od;
	} fifo_s;

	fifo_s s;
	fifo_s next_s;
	logic  push;
	logic  load;

	// ------------------------------------------------------------
	// Next state: memory plus one output register
	// ------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		push = in_valid && (s.cnt != CNT_FULL);
		load = (s.cnt != '0) && (!s.ov || out_ready);
		if (push)
		begin
			next_s.mem[s.wp] = in_data;
			next_s.wp = s.wp + AW'(1);
		end
		// Output register refills in the cycle it is taken
		if (load)
		begin
			next_s.od = s.mem[s.rp];
			next_s.rp = s.rp + AW'(1);
			next_s.ov = 1'b1;
		end
		else if (s.ov && out_ready)
		begin
			next_s.ov = 1'b0;
		end
		if (push && !load)
			next_s.cnt = s.cnt + (AW+1)'(1);
		else if (load && !push)
			next_s.cnt = s.cnt - (AW+1)'(1);
	end

	// State register
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	// Outputs; full counts memory words only, so room is exact
	assign in_ready  = (s.cnt != CNT_FULL);
	assign out_valid = s.ov;
	assign out_data  = s.od;
	assign level     = {1'b0, s.cnt} + {{(AW+1){1'b0}}, s.ov};

endmodule
`default_nettype wire

//--- logic/fold_flow.sv
// Flow control and packet sequencing front end of a folded datapath
// Notes on behaviour
// RULE1 - Ready high while the shared engine idles; here ready also needs room in the result FIFO
// RULE2 - Idle after reset and after each sample
// RULE3 - Source pulses start only on first cycle
// RULE4 - Start strobe while busy is ignored
// RULE5 - Busy, ready low, from cycle after accept
// RULE6 - Multichannel always uses start strobe both sides
// RULE7 - Valid mode never starts on low valid
// RULE8 - Unheld output: data only in result cycle
// RULE9 - Held output keeps result until next
// RULE10 - Each packet finishes within maximum latency
// RULE11 - Stored state kept separate per channel
// RULE12 - Channel state changes only when processed
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fold_flow (
	input  wire logic                       mclk,              // 250 MHz
	input  wire logic                       rst_n,             // Sync, low
	input  wire logic [fold_pkg::ADDR_W-1:0] reg_addr,         // Byte addr
	input  wire logic [31:0]                reg_wdata,         // Write data
	input  wire logic                       reg_wr,            // Write strobe
	input  wire logic                       reg_rd,            // Read strobe
	output logic [31:0]                     reg_rdata,         // Next cycle
	input  wire logic                       in_sop,            // Start strobe
	input  wire logic                       in_valid,          // Qualifier
	input  wire fold_pkg::sample_s          sample_input_port, // Ch + data
	output logic                            ready,             // Idle, FIFO room
	input  wire logic                       out_ready,         // Sink ready
	output logic                            out_sop,           // Start out
	output logic                            out_valid,         // Result pulse
	output fold_pkg::sample_s               sample_output_port // Ch + data
);
	localparam int DW  = fold_pkg::DATA_W;
	localparam int NCH = fold_pkg::NUM_CH;
	localparam int FW  = fold_pkg::CH_W + fold_pkg::DATA_W;
	localparam int LW  = $clog2(fold_pkg::FIFO_DEPTH) + 2;

	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------
	typedef struct packed {
		fold_pkg::proc_e                  st;
		fold_pkg::sample_s                cur;
		logic [fold_pkg::CYC_W-1:0]       elapsed;
		logic [NCH-1:0][DW-1:0]           delay;
		logic                             pso;
		logic                             hold;
		logic [fold_pkg::CH_W-1:0]        chn;
		logic [fold_pkg::CYC_W-1:0]       op_cycles;
		logic [fold_pkg::CYC_W-1:0]       max_lat;
		logic                             late;
		logic                             drop;
		logic [31:0]                      rdata;
		logic                             ovalid;
		logic                             osop;
		fold_pkg::sample_s                odata;
	} flow_s;

	flow_s             s;
	flow_s             next_s;
	logic              eff_pso;
	logic              strobe_ok;
	logic              ch_ok;
	logic              accept;
	logic              finish;
	logic              cut_short;
	logic              fifo_in_ready;
	logic              fifo_out_valid;
	logic [FW-1:0]     fifo_out_data;
	logic [LW-1:0]     fifo_level;
	fold_pkg::sample_s result;
	fold_pkg::sample_s popped;
	logic [31:0]       status_word;

	// ------------------------------------------------------------
	// Acceptance decode
	// ------------------------------------------------------------
	// More than one channel forces start-strobe framing
	assign eff_pso = s.pso || (s.chn != '0); // see RULE6
	// Valid mode only starts on a qualified sample
	assign strobe_ok = eff_pso ? in_sop : in_valid; // see RULE7
	assign ch_ok = (sample_input_port.ch <= s.chn);
	// Ready needs an idle engine and a free slot for the result
	assign ready = (s.st == fold_pkg::ST_IDLE) && fifo_in_ready; // see RULE1
	// Busy engine never takes a strobe
	assign accept = ready && strobe_ok && ch_ok; // see RULE4

	// ------------------------------------------------------------
	// Completion and result
	// ------------------------------------------------------------
	// Ends at the op length, or is cut at the latency limit
	assign cut_short = ({1'b0, s.elapsed} + 9'h001) >= {1'b0, s.max_lat};
	assign finish = (s.st == fold_pkg::ST_BUSY) &&
		(((({1'b0, s.elapsed} + 9'h001) >= {1'b0, s.op_cycles})) ||
		cut_short); // see RULE10
	// Two-tap sum with the channel's own previous sample
	assign result.ch   = s.cur.ch;
	assign result.data = s.cur.data + s.delay[s.cur.ch]; // see RULE11
	assign popped      = fold_pkg::sample_s'(fifo_out_data);

	// Status word as seen by software
	always_comb
	begin
		status_word = '0;
		status_word[fold_pkg::STAT_IDLE_BIT] = (s.st == fold_pkg::ST_IDLE);
		status_word[fold_pkg::STAT_EMPTY] = (fifo_level == '0);
		status_word[fold_pkg::STAT_FULL] = !fifo_in_ready;
		status_word[fold_pkg::STAT_LATE] = s.late;
		status_word[fold_pkg::STAT_DROP] = s.drop;
		status_word[fold_pkg::STAT_LVL_LSB +: LW] = fifo_level;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.rdata = '0;
		next_s.ovalid = 1'b0;
		next_s.osop = 1'b0;
		// Register writes
		if (reg_wr)
		begin
			case (reg_addr)
				fold_pkg::OFS_CTRL:
				begin
					next_s.pso  = reg_wdata[fold_pkg::CTRL_PSO_BIT];
					next_s.hold = reg_wdata[fold_pkg::CTRL_HOLD_BIT];
					next_s.chn  =
						reg_wdata[fold_pkg::CTRL_CHN_LSB +: fold_pkg::CH_W];
				end
				fold_pkg::OFS_TIMING:
				begin
					next_s.op_cycles =
						reg_wdata[fold_pkg::TIM_OP_LSB +: fold_pkg::CYC_W];
					next_s.max_lat =
						reg_wdata[fold_pkg::TIM_MAX_LSB +: fold_pkg::CYC_W];
				end
				fold_pkg::OFS_STATUS:
				begin
					// Write one to clear; a new event below still wins
					if (reg_wdata[fold_pkg::STAT_LATE])
						next_s.late = 1'b0;
					if (reg_wdata[fold_pkg::STAT_DROP])
						next_s.drop = 1'b0;
				end
				default:
				begin
					next_s.late = s.late;
				end
			endcase
		end
		// Register reads, answered in the next cycle only
		if (reg_rd)
		begin
			if (reg_addr == fold_pkg::OFS_CTRL)
				next_s.rdata = {28'h0000000, s.chn, s.hold, s.pso};
			else if (reg_addr == fold_pkg::OFS_TIMING)
				next_s.rdata = {16'h0000, s.max_lat, s.op_cycles};
			else if (reg_addr == fold_pkg::OFS_STATUS)
				next_s.rdata = status_word;
			else if (reg_addr[7:4] == fold_pkg::CHAN_PAGE)
				next_s.rdata = {16'h0000, s.delay[reg_addr[3:2]]};
			else
				next_s.rdata = '0;
		end
		// A strobe seen while the engine works is noted, not taken
		if (strobe_ok && (s.st == fold_pkg::ST_BUSY))
			next_s.drop = 1'b1; // see RULE4
		// Engine sequencing
		case (s.st)
			fold_pkg::ST_IDLE:
			begin
				next_s.elapsed = '0;
				if (accept)
				begin
					next_s.cur = sample_input_port;
					next_s.st  = fold_pkg::ST_BUSY; // see RULE5
				end
			end
			fold_pkg::ST_BUSY:
			begin
				if (finish)
				begin
					// Only the processed channel's tap moves
					next_s.delay[s.cur.ch] = s.cur.data; // see RULE12
					next_s.st = fold_pkg::ST_IDLE; // see RULE2
					if (cut_short && (s.op_cycles > s.max_lat))
						next_s.late = 1'b1;
				end
				else
				begin
					next_s.elapsed = s.elapsed + 8'h01;
				end
			end
			default:
			begin
				next_s.st = fold_pkg::ST_IDLE;
			end
		endcase
		// Output stage: one pulse per popped result
		if (fifo_out_valid && out_ready)
		begin
			next_s.ovalid = 1'b1;
			next_s.osop = eff_pso; // see RULE6
			next_s.odata = popped; // see RULE9
		end
		else if (!s.hold)
		begin
			// Unheld data reads zero outside its result cycle
			next_s.odata = '0; // see RULE8
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.st <= fold_pkg::ST_IDLE;
			s.pso <= fold_pkg::RST_PSO;
			s.hold <= fold_pkg::RST_HOLD;
			s.chn <= fold_pkg::RST_CHN;
			s.op_cycles <= fold_pkg::RST_OP_CYCLES;
			s.max_lat <= fold_pkg::RST_MAX_LAT;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Result buffer; room is checked at accept so a push never fails
	// ------------------------------------------------------------
	fifo_buf #(
		.W     (FW),
		.DEPTH (fold_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_valid  (finish),
		.in_ready  (fifo_in_ready),
		.in_data   (result),
		.out_valid (fifo_out_valid),
		.out_ready (out_ready),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);

	// Outputs from flip-flops
	assign reg_rdata          = s.rdata;
	assign out_valid          = s.ovalid;
	assign out_sop            = s.osop;
	assign sample_output_port = s.odata;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// Helper: busy run length, independent of the engine counter
	logic [8:0] lat_cnt;
	always_ff @(posedge mclk)
	begin
		if (!rst_n || (s.st != fold_pkg::ST_BUSY))
			lat_cnt <= 9'h001;
		else
			lat_cnt <= lat_cnt + 9'h001;
	end

	chk_ready_after_done: assert property ( // see RULE1
		finish |=> (s.st == fold_pkg::ST_IDLE) && (ready || !fifo_in_ready))
		else $error("ready not back after completion");

	chk_idle_out_reset: assert property ( // see RULE2
		$past(!rst_n) |-> (s.st == fold_pkg::ST_IDLE) && !out_valid)
		else $error("not idle after reset");

	chk_busy_after_accept: assert property ( // see RULE5
		accept |=> (s.st == fold_pkg::ST_BUSY) && !ready)
		else $error("ready high after accept");

	chk_busy_ignores_strobe: assert property ( // see RULE4
		(s.st == fold_pkg::ST_BUSY) && !finish && in_sop
		|=> (s.st == fold_pkg::ST_BUSY) && $stable(s.cur))
		else $error("strobe taken while busy");

	chk_valid_gate: assert property ( // see RULE7
		(s.st == fold_pkg::ST_IDLE) && !eff_pso && !in_valid
		|=> (s.st == fold_pkg::ST_IDLE))
		else $error("started on low valid");

	chk_unheld_zero: assert property ( // see RULE8
		!s.hold && $past(!s.hold) && !out_valid
		|-> (sample_output_port == '0))
		else $error("unheld data outside result cycle");

	chk_held_stable: assert property ( // see RULE9
		s.hold && $past(s.hold) && !out_valid
		|-> $stable(sample_output_port))
		else $error("held output changed");

	chk_latency_bound: assert property ( // see RULE10
		(s.st == fold_pkg::ST_BUSY)
		|-> (lat_cnt <= {1'b0, s.max_lat}) || (lat_cnt == 9'h001))
		else $error("packet over latency limit");

	chk_tap_update: assert property ( // see RULE11
		finish |=> s.delay[$past(s.cur.ch)] == $past(s.cur.data))
		else $error("channel tap not updated");

	chk_tap_frozen: assert property ( // see RULE12
		!finish |=> $stable(s.delay))
		else $error("tap changed outside processing");

	chk_drop_noted: assert property ( // see RULE4
		(s.st == fold_pkg::ST_BUSY) && strobe_ok |=> s.drop)
		else $error("strobe while busy not noted");

	// Tap of channel zero must not move for another channel's sample
	chk_tap_isolated: assert property ( // see RULE11
		finish && (s.cur.ch != 2'h0) |=> $stable(s.delay[0]))
		else $error("foreign channel moved tap zero");

	chk_multi_sop: assert property ( // see RULE6
		out_valid && $past(s.chn != 2'h0) |-> out_sop)
		else $error("multichannel result without start");

	chk_result_pulse: assert property ( // see RULE8
		out_valid && !(fifo_out_valid && out_ready) |=> !out_valid)
		else $error("result pulse longer than one cycle");

endmodule
`default_nettype wire

//--- dv/result_sink.sv
// Downstream consumer model that takes results from the folded front end
`timescale 1ns/1ps
`default_nettype none
module result_sink (
	input  wire logic              mclk,              // Core clock
	input  wire logic              rst_n,             // Sync reset, low
	input  wire logic              stall,             // Hold off popping
	output logic                   out_ready,         // Sink ready
	input  wire logic              out_valid,         // Result pulse
	input  wire logic              out_sop,           // Start out
	input  wire fold_pkg::sample_s sample_output_port // Result word
);
	// ----
	// Capture
	// ----
	logic [18:0] got[$];

	// Registered ready, so a stall lands one edge late as in real logic
	always @(posedge mclk)
	begin
		out_ready <= rst_n && !stall;
		if (rst_n && out_valid === 1'b1)
			got.push_back({out_sop, sample_output_port});
	end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench of the folded flow front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic              mclk;
	logic              rst_n;
	logic [7:0]        reg_addr;
	logic [31:0]       reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [31:0]       reg_rdata;
	logic              in_sop;
	logic              in_valid;
	fold_pkg::sample_s sin;
	fold_pkg::sample_s sout;
	logic              ready;
	logic              out_ready;
	logic              out_sop;
	logic              out_valid;
	logic              stall;
	logic              smode;
	logic [15:0]       prev [4];
	logic [18:0]       exp_q[$];
	logic [31:0]       rd;
	int                n_mismatch;
	int                checks_done;
	int                n;

	fold_flow fold_flow_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .in_sop(in_sop), .in_valid(in_valid),
		.sample_input_port(sin), .ready(ready), .out_ready(out_ready),
		.out_sop(out_sop), .out_valid(out_valid), .sample_output_port(sout));
	result_sink result_sink_i (.mclk(mclk), .rst_n(rst_n), .stall(stall),
		.out_ready(out_ready), .out_valid(out_valid), .out_sop(out_sop),
		.sample_output_port(sout));

	// ----
	// Clock and watchdog
	// ----
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// Run needs some 500 cycles; allow far more
	initial
	begin
		#200000;
		n_mismatch++;
		give_verdict();
	end

	// ----
	// Shared tasks
	// ----
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		rd = reg_rdata;
	endtask

	// One-cycle valid, with start strobe when smode, on the first cycle only; data then scrambled
	task automatic send(input logic [1:0] ch, input logic [15:0] d);
		n = 0;
		// Settle first: a back-to-back call would still see the old ready
		@(negedge mclk);
		while (ready !== 1'b1 && n < 100)
		begin
			n++;
			@(negedge mclk);
		end
		if (ready !== 1'b1)
			check("ready wait", ready, 1);
		@(posedge mclk);
		in_sop <= smode;
		in_valid <= 1'b1;
		sin <= '{ch, d};
		@(posedge mclk);
		in_sop <= 1'b0;
		in_valid <= 1'b0;
		sin <= ~sin;
		exp_q.push_back({smode, ch, d + prev[ch]});
		prev[ch] = d;
	endtask

	task automatic busy_len(input int exp);
		n = 0;
		@(negedge mclk);
		while (ready === 1'b0 && n < 50)
		begin
			n++;
			@(negedge mclk);
		end
		check("busy cycles", n, exp);
	endtask

	task automatic take();
		n = 0;
		while (result_sink_i.got.size() == 0 && n < 200)
		begin
			n++;
			@(negedge mclk);
		end
		if (result_sink_i.got.size() == 0 || exp_q.size() == 0)
			check("result present", 0, 1);
		else
			check("result", result_sink_i.got.pop_front(), exp_q.pop_front());
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		check("ready after reset", ready, 1);
		reg_read(fold_pkg::OFS_CTRL);
		check("ctrl", rd, 32'h00000001);
		reg_read(fold_pkg::OFS_TIMING);
		check("timing", rd, 32'h00001004);
		reg_read(fold_pkg::OFS_STATUS);
		check("status", rd, 32'h00000003);
		reg_read(8'h0C);
		check("unmapped", rd, 32'h00000000);
	endtask

	task automatic t_basic();
		send(2'h0, 16'h1234);
		busy_len(4);
		take();
		check("valid after", out_valid, 0);
		check("unheld data", sout, 0);
	endtask

	task automatic t_busy_sop();
		send(2'h0, 16'h0101);
		@(posedge mclk);
		in_sop <= 1'b1;
		// Legal channel, so only the busy engine can refuse it
		sin <= '{2'h0, 16'h4444};
		@(posedge mclk);
		in_sop <= 1'b0;
		take();
		repeat (20) @(negedge mclk);
		check("extra result", result_sink_i.got.size(), 0);
		reg_read(fold_pkg::OFS_STATUS);
		check("drop flag", rd[fold_pkg::STAT_DROP], 1);
		reg_write(fold_pkg::OFS_STATUS, 32'h00000010);
		reg_read(fold_pkg::OFS_STATUS);
		check("drop clear", rd[fold_pkg::STAT_DROP], 0);
	endtask

	task automatic t_valid();
		smode = 1'b0;
		reg_write(fold_pkg::OFS_CTRL, 32'h00000000);
		@(posedge mclk);
		in_sop <= 1'b1;
		// Legal channel, so only the low valid can refuse it
		sin <= '{2'h0, 16'h5555};
		@(posedge mclk);
		in_sop <= 1'b0;
		repeat (12) @(negedge mclk);
		check("low valid result", result_sink_i.got.size(), 0);
		check("low valid ready", ready, 1);
		send(2'h0, 16'h0A0A);
		take();
		smode = 1'b1;
	endtask

	task automatic t_hold();
		reg_write(fold_pkg::OFS_CTRL, 32'h00000003);
		send(2'h0, 16'h7F00);
		rd = exp_q[$];
		take();
		repeat (6) @(negedge mclk);
		check("held data", sout, rd[17:0]);
		reg_write(fold_pkg::OFS_CTRL, 32'h00000001);
	endtask

	task automatic t_multi();
		// Start mode off: four channels must force start framing
		reg_write(fold_pkg::OFS_CTRL, 32'h0000000C);
		send(2'h2, 16'h0011);
		send(2'h3, 16'h0200);
		send(2'h2, 16'h0022);
		repeat (3) take();
		reg_read(8'h18);
		check("tap two", rd[15:0], prev[2]);
		reg_read(8'h1C);
		check("tap three", rd[15:0], prev[3]);
		reg_write(fold_pkg::OFS_CTRL, 32'h00000001);
	endtask

	task automatic t_late();
		reg_write(fold_pkg::OFS_TIMING, 32'h00000308);
		send(2'h0, 16'h0003);
		busy_len(3);
		take();
		reg_read(fold_pkg::OFS_STATUS);
		check("late flag", rd[fold_pkg::STAT_LATE], 1);
		reg_write(fold_pkg::OFS_STATUS, 32'h00000008);
		reg_read(fold_pkg::OFS_STATUS);
		check("late clear", rd[fold_pkg::STAT_LATE], 0);
		reg_write(fold_pkg::OFS_TIMING, 32'h00001004);
	endtask

	// Sink stalls until the result path is full, then drains it all
	task automatic t_fill();
		stall <= 1'b1;
		repeat (3) @(posedge mclk);
		for (int i = 0; i < 33; i++)
			send(2'h0, 16'(i + 16'h0100));
		repeat (10) @(negedge mclk);
		check("ready when full", ready, 0);
		reg_read(fold_pkg::OFS_STATUS);
		check("level", rd[14:8], 33);
		check("full", rd[fold_pkg::STAT_FULL], 1);
		stall <= 1'b0;
		repeat (33) take();
		check("ready drained", ready, 1);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----
	// Main sequence
	// ----
	initial
	begin
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		in_sop = 1'b0;
		in_valid = 1'b0;
		sin = '0;
		stall = 1'b0;
		smode = 1'b1;
		n_mismatch = 0;
		checks_done = 0;
		for (int c = 0; c < 4; c++)
			prev[c] = 16'h0000;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		t_reset();
		t_basic();
		t_busy_sop();
		t_valid();
		t_hold();
		t_multi();
		t_late();
		t_fill();
		give_verdict();
	end
endmodule
`default_nettype wire
